// File: core/class_setting_store.v
// retained storage for the realtime data error class setting
module class_setting_store #(
    parameter WIDTH = 16
) (
    input  wire             mclk,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    output reg  [WIDTH-1:0] rd_data
);
    // no reset: the value is kept across power cycles by retention
    reg [WIDTH-1:0] mem_reg;
    initial mem_reg = {WIDTH{1'b0}};
    always @(posedge mclk) begin
        if (wr_en) begin
            mem_reg <= wr_data;
        end
        rd_data <= wr_en ? wr_data : mem_reg;
    end
endmodule

// File: core/drive_fault_classifier.v
// drive fault classifier and response selector
// Behaviour
// [RQ1] bad realtime data writes take class 0 or 1 per setting, default 0
// [RQ2] class setting change acts at once and is retained over power cycle
// [RQ3] each detected error raises a message with code and class; code sends one per cycle (monitor, realtime, access) and drops the rest
// [RQ4] leading hex digit of the code gives the error range
// [RQ5] class 0: no state change, motion continues, fault reset clears
// [RQ6] class 1: fast stop transition, fault reset clears
// [RQ7] class 2: fast stop then disable stage at standstill, reset clears
// [RQ8] class 3: disable stage at once without stopping, reset clears
// [RQ9] class 4: disable stage at once, only power cycle clears
// [RQ10] out of range parameter write is rejected with class 0 code
// [RQ11] missing index and missing subindex report separate class 0 codes
// [RQ12] write to read only parameter refused with class 0 code
// [RQ13] expert parameter write needs expert level, else class 0 code
// [RQ14] some commands refused while power stage enabled, class 0 code
// [RQ15] access from a second channel is blocked, class 0 code
// [RQ16] recorded error class exposed as 16 bit value 0 to 4
// [RQ17] highest pending class latched until its clearing action
`include "fault_class_map.vh"
module drive_fault_classifier (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        power_on_rst,
    input  wire        mon_err_valid,
    input  wire [15:0] mon_err_code,
    input  wire [2:0]  mon_err_class,
    input  wire        rt_data_bad,
    input  wire        acc_valid,
    input  wire        acc_write,
    input  wire [1:0]  acc_channel,
    input  wire [15:0] acc_addr,
    input  wire [15:0] acc_wdata,
    input  wire        acc_index_ok,
    input  wire        acc_subindex_ok,
    input  wire        acc_read_only,
    input  wire        acc_expert,
    input  wire        acc_in_range,
    input  wire        acc_needs_stage_off,
    input  wire        acc_release,
    input  wire        expert_level,
    input  wire        fault_reset,
    input  wire        motor_standstill,
    output reg         acc_done,
    output reg         acc_error,
    output reg  [15:0] acc_rdata,
    output reg         err_msg_valid,
    output reg  [15:0] err_msg_code,
    output reg  [15:0] err_msg_class,
    output reg  [3:0]  err_msg_range,
    output reg  [15:0] recorded_error_class,
    output reg         fault_active,
    output reg         transition_to_fast_stop,
    output reg         transition_to_fault_reaction,
    output reg         transition_to_fault_state,
    output reg         fast_stop_req,
    output reg         stage_disable,
    output reg         stage_enabled
);
    // response state
    localparam ST_RUN       = 3'h0;
    localparam ST_FAST_STOP = 3'h1;
    localparam ST_REACT     = 3'h2;
    localparam ST_FAULT     = 3'h3;

    reg  [2:0]  state_reg;
    reg  [2:0]  latched_class_reg;
    reg         pending_reg;
    reg  [1:0]  owner_reg;
    reg         owned_reg;
    wire [15:0] rt_class_sel;
    wire        setting_wr;
    reg  [15:0] acc_code;
    reg         acc_bad;
    reg  [15:0] ev_code;
    reg  [2:0]  ev_class;
    reg         ev_valid;

    function [2:0] max_class;
        input [2:0] a;
        input [2:0] b;
        begin
            max_class = (a > b) ? a : b;
        end
    endfunction

    // response state entered from run for one event
    function [2:0] react_state;
        input       valid;
        input [2:0] cls;
        begin
            if (!valid) begin
                react_state = ST_RUN;
            end else if (cls == `CLASS_QUICK_STOP) begin
                react_state = ST_FAST_STOP; // [RQ6]
            end else if (cls == `CLASS_STOP_DISABLE) begin
                react_state = ST_REACT; // [RQ7]
            end else if (cls >= `CLASS_DISABLE) begin
                react_state = ST_FAULT; // [RQ8] [RQ9]
            end else begin
                react_state = ST_RUN; // [RQ5]
            end
        end
    endfunction

    // write of the class setting, accepted only when access is clean
    assign setting_wr = acc_valid && acc_write && !acc_bad &&
                        acc_addr == `REG_RT_DATA_ERROR_CLASS;

    class_setting_store #(
        .WIDTH(16)
    ) u_store (
        .mclk    (mclk),
        .wr_en   (setting_wr),
        .wr_data (acc_wdata),
        .rd_data (rt_class_sel)
    );

    // access checks in priority order
    always @* begin
        acc_bad  = 1'b1;
        acc_code = 16'h0000;
        if (owned_reg && acc_channel != owner_reg) begin
            acc_code = `CODE_CHANNEL_BLOCKED; // [RQ15]
        end else if (!acc_index_ok) begin
            acc_code = `CODE_NO_INDEX; // [RQ11]
        end else if (!acc_subindex_ok) begin
            acc_code = `CODE_NO_SUBINDEX; // [RQ11]
        end else if (acc_write && acc_read_only) begin
            acc_code = `CODE_READ_ONLY; // [RQ12]
        end else if (acc_write && acc_expert && !expert_level) begin
            acc_code = `CODE_NO_AUTH; // [RQ13]
        end else if (acc_needs_stage_off && stage_enabled) begin
            acc_code = `CODE_STAGE_ACTIVE; // [RQ14]
        end else if (acc_write && (!acc_in_range ||
                     (acc_addr == `REG_RT_DATA_ERROR_CLASS &&
                      acc_wdata > `RT_CLASS_MAX))) begin
            acc_code = `CODE_OUT_OF_RANGE; // [RQ10]
        end else begin
            acc_bad = 1'b0;
        end
    end

    // event selection: monitor first, then realtime data, then access
    always @* begin
        ev_valid = 1'b1;
        ev_code  = mon_err_code;
        ev_class = mon_err_class;
        if (mon_err_valid) begin
            ev_code  = mon_err_code; // [RQ3]
            ev_class = mon_err_class;
        end else if (rt_data_bad) begin
            ev_code  = `CODE_OUT_OF_RANGE;
            ev_class = (rt_class_sel[0]) ? `CLASS_QUICK_STOP
                                         : `CLASS_WARN; // [RQ1] [RQ2]
        end else if (acc_valid && acc_bad) begin
            ev_code  = acc_code;
            ev_class = `CLASS_WARN;
        end else begin
            ev_valid = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            acc_done      <= 1'b0;
            acc_error     <= 1'b0;
            acc_rdata     <= 16'h0000;
            err_msg_valid <= 1'b0;
            err_msg_code  <= 16'h0000;
            err_msg_class <= 16'h0000;
            err_msg_range <= 4'h0;
            owner_reg     <= 2'h0;
            owned_reg     <= 1'b0;
        end else begin
            acc_done  <= acc_valid;
            acc_error <= acc_valid && acc_bad;
            if (acc_valid && !acc_bad && !acc_write) begin
                acc_rdata <= (acc_addr == `REG_RT_DATA_ERROR_CLASS) ?
                             rt_class_sel : {13'h0000, latched_class_reg};
            end
            if (acc_release && owned_reg && acc_channel == owner_reg) begin
                owned_reg <= 1'b0;
            end else if (acc_valid && !owned_reg) begin
                owned_reg <= 1'b1; // [RQ15]
                owner_reg <= acc_channel;
            end
            err_msg_valid <= ev_valid; // [RQ3]
            if (ev_valid) begin
                err_msg_code  <= ev_code;
                err_msg_class <= {13'h0000, ev_class};
                err_msg_range <= ev_code[15:12]; // [RQ4]
            end
        end
    end

    // latched class and response sequence
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_reg         <= ST_RUN;
            latched_class_reg <= `CLASS_WARN;
            pending_reg       <= 1'b0;
        end else begin
            if (power_on_rst ||
                (fault_reset && latched_class_reg != `CLASS_POWER_CYCLE)) begin
                pending_reg       <= ev_valid; // [RQ5] [RQ9] [RQ17]
                latched_class_reg <= ev_valid ? ev_class : `CLASS_WARN;
                // an event in the clearing cycle still takes effect
                state_reg         <= react_state(ev_valid, ev_class);
            end else begin
                if (ev_valid) begin
                    pending_reg       <= 1'b1;
                    latched_class_reg <= pending_reg ?
                        max_class(latched_class_reg, ev_class) :
                        ev_class; // [RQ17]
                end
                case (state_reg)
                    ST_RUN: begin
                        state_reg <= react_state(ev_valid, ev_class);
                    end
                    ST_FAST_STOP: begin
                        if (ev_valid && ev_class == `CLASS_STOP_DISABLE)
                            state_reg <= ST_REACT;
                        else if (ev_valid && ev_class >= `CLASS_DISABLE)
                            state_reg <= ST_FAULT;
                    end
                    ST_REACT: begin
                        if (motor_standstill ||
                            (ev_valid && ev_class >= `CLASS_DISABLE))
                            state_reg <= ST_FAULT; // [RQ7]
                    end
                    ST_FAULT: begin
                        state_reg <= ST_FAULT;
                    end
                    default: begin
                        state_reg <= ST_RUN;
                    end
                endcase
            end
        end
    end

    // registered response outputs
    always @(posedge mclk) begin
        if (sys_rst) begin
            recorded_error_class         <= 16'h0000;
            fault_active                 <= 1'b0;
            transition_to_fast_stop      <= 1'b0;
            transition_to_fault_reaction <= 1'b0;
            transition_to_fault_state    <= 1'b0;
            fast_stop_req                <= 1'b0;
            stage_disable                <= 1'b0;
            stage_enabled                <= 1'b0;
        end else begin
            recorded_error_class <= {13'h0000, latched_class_reg}; // [RQ16]
            fault_active <= pending_reg;
            transition_to_fast_stop <= state_reg == ST_FAST_STOP; // [RQ6]
            transition_to_fault_reaction <= state_reg == ST_REACT ||
                                            state_reg == ST_FAULT;
            transition_to_fault_state <= state_reg == ST_FAULT;
            fast_stop_req <= state_reg == ST_FAST_STOP ||
                             state_reg == ST_REACT; // [RQ7]
            stage_disable <= state_reg == ST_FAULT; // [RQ8]
            stage_enabled <= state_reg != ST_FAULT;
        end
    end
endmodule

// File: core/fault_class_map.vh
// constants for the drive fault classifier
`ifndef FAULT_CLASS_MAP_VH
`define FAULT_CLASS_MAP_VH
`define REG_RT_DATA_ERROR_CLASS 16'h190c
`define RT_DATA_ERROR_CLASS_RST 16'h0000
`define RT_CLASS_MAX            16'h0001
`define CODE_OUT_OF_RANGE       16'h1100
`define CODE_NO_INDEX           16'h1101
`define CODE_NO_SUBINDEX        16'h1102
`define CODE_READ_ONLY          16'h1103
`define CODE_NO_AUTH            16'h1104
`define CODE_STAGE_ACTIVE       16'h1106
`define CODE_CHANNEL_BLOCKED    16'h1107
`define RANGE_GENERAL           4'h1
`define RANGE_OVERCURRENT       4'h2
`define RANGE_VOLTAGE           4'h3
`define RANGE_TEMPERATURE       4'h4
`define RANGE_HARDWARE          4'h5
`define RANGE_SOFTWARE          4'h6
`define RANGE_INTERFACE         4'h7
`define RANGE_FIELDBUS          4'h8
`define RANGE_MOTION            4'ha
`define RANGE_COMM              4'hb
`define CLASS_WARN              3'h0
`define CLASS_QUICK_STOP        3'h1
`define CLASS_STOP_DISABLE      3'h2
`define CLASS_DISABLE           3'h3
`define CLASS_POWER_CYCLE       3'h4
`endif

// File: verification/fault_classifier_props.sv
// assertion checker for the drive fault classifier ports
module fault_classifier_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        power_on_rst,
    input wire logic        fault_reset,
    input wire logic        mon_err_valid,
    input wire logic        rt_data_bad,
    input wire logic        acc_valid,
    input wire logic        acc_done,
    input wire logic        acc_error,
    input wire logic        err_msg_valid,
    input wire logic        fault_active,
    input wire logic        fast_stop_req,
    input wire logic        stage_disable,
    input wire logic        stage_enabled,
    input wire logic [15:0] mon_err_code,
    input wire logic [2:0]  mon_err_class,
    input wire logic [15:0] err_msg_code,
    input wire logic [15:0] err_msg_class,
    input wire logic [3:0]  err_msg_range,
    input wire logic [15:0] recorded_error_class
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || power_on_rst);
    property p_done; acc_valid |=> acc_done; endproperty
    a_done: assert property (p_done) else $error("access not answered");
    property p_msg;
        mon_err_valid |=> err_msg_valid && err_msg_code == $past(mon_err_code);
    endproperty
    a_msg: assert property (p_msg) else $error("no message");
    property p_rng; err_msg_valid |-> err_msg_range == err_msg_code[15:12];
    endproperty
    a_rng: assert property (p_rng) else $error("bad range digit");
    property p_cls; recorded_error_class <= 16'h0004; endproperty
    a_cls: assert property (p_cls) else $error("class above 4");
    property p_c0;
        mon_err_valid && mon_err_class == 3'h0 && !fast_stop_req
        && !stage_disable && !$past(mon_err_valid) && !$past(rt_data_bad)
        ##1 !mon_err_valid && !rt_data_bad
        |=> !fast_stop_req && !stage_disable;
    endproperty
    a_c0: assert property (p_c0) else $error("class 0 stopped");
    property p_c1;
        mon_err_valid && mon_err_class == 3'h1 && !stage_disable
        && !fault_active && !$past(mon_err_valid)
        ##1 !fault_reset && !mon_err_valid |=> fast_stop_req;
    endproperty
    a_c1: assert property (p_c1) else $error("class 1 no stop");
    property p_c3; mon_err_valid && mon_err_class >= 3'h3 ##1 !fault_reset
        |=> stage_disable && !stage_enabled;
    endproperty
    a_c3: assert property (p_c3) else $error("stage on");
    property p_c4; recorded_error_class == 16'h0004 && fault_reset
        |=> recorded_error_class == 16'h0004;
    endproperty
    a_c4: assert property (p_c4) else $error("class 4 cleared");
    property p_clr; fault_reset && recorded_error_class < 16'h0004
        && !$past(mon_err_valid && mon_err_class == 3'h4)
        && !mon_err_valid && !rt_data_bad && !acc_valid
        |=> ##1 !fault_active;
    endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_ref; acc_valid && !mon_err_valid && !rt_data_bad ##1 acc_error
        |-> err_msg_valid && err_msg_class == 16'h0000;
    endproperty
    a_ref: assert property (p_ref) else $error("refusal not class 0");
endmodule
bind drive_fault_classifier fault_classifier_props chk_u (.*);

// File: verification/param_table_model.sv
// parameter attribute table answering for the host side dictionary
module param_table_model (
    input  wire logic [15:0] acc_addr,
    input  wire logic [15:0] acc_wdata,
    output logic             index_ok,
    output logic             subindex_ok,
    output logic             read_only,
    output logic             expert,
    output logic             in_range,
    output logic             needs_stage_off
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        index_ok = acc_addr != 16'h0001;
        subindex_ok = acc_addr != 16'h0002;
        read_only = acc_addr == 16'h0003;
        expert = acc_addr == 16'h0004;
        needs_stage_off = acc_addr == 16'h0006;
        in_range = acc_wdata <= ((acc_addr == 16'h190c) ? 16'h0001 : 16'h0064);
    end
endmodule

// File: verification/test_drive_fault_classifier.sv
// testbench for the drive fault classifier
`define CHK(n, a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module test_drive_fault_classifier;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, por = 0, mev = 0, rtb = 0, av = 0, aw = 0;
    logic rel = 0, xl = 0, frs = 0, still = 0;
    logic [1:0] ch = 0;
    logic [2:0] mcl = 0;
    logic [15:0] mcode = 0, aa = 0, wd = 0, rd, code, cls, rec;
    logic done, err, mv, fa, t11, t13, t14, fs, sd, se, io, so, ro, ex, ir, ns;
    logic [3:0] rng;
    int n_mismatch = 0, checks = 0, i;
    logic [15:0] ra [7] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h6, 16'h10, 16'h190c};
    logic [15:0] rw [7] = '{0, 0, 0, 0, 0, 16'hc8, 16'h2};
    logic [15:0] rc [7] = '{16'h1101, 16'h1102, 16'h1103, 16'h1104, 16'h1106,
                            16'h1100, 16'h1100};
    logic [3:0] rg [10] = '{1, 2, 3, 4, 5, 6, 7, 8, 4'ha, 4'hb};
    initial forever #5 mclk = ~mclk;
    param_table_model pt_u (.acc_addr(aa), .acc_wdata(wd), .index_ok(io),
        .subindex_ok(so), .read_only(ro), .expert(ex), .in_range(ir),
        .needs_stage_off(ns));
    drive_fault_classifier dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .power_on_rst(por), .mon_err_valid(mev), .mon_err_code(mcode),
        .mon_err_class(mcl), .rt_data_bad(rtb), .acc_valid(av),
        .acc_write(aw), .acc_channel(ch), .acc_addr(aa), .acc_wdata(wd),
        .acc_index_ok(io), .acc_subindex_ok(so), .acc_read_only(ro),
        .acc_expert(ex), .acc_in_range(ir), .acc_needs_stage_off(ns),
        .acc_release(rel), .expert_level(xl), .fault_reset(frs),
        .motor_standstill(still), .acc_done(done), .acc_error(err),
        .acc_rdata(rd), .err_msg_valid(mv), .err_msg_code(code),
        .err_msg_class(cls), .err_msg_range(rng),
        .recorded_error_class(rec), .fault_active(fa),
        .transition_to_fast_stop(t11), .transition_to_fault_reaction(t13),
        .transition_to_fault_state(t14), .fast_stop_req(fs),
        .stage_disable(sd), .stage_enabled(se));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [1:0] c,
                       input logic [15:0] a, d, input logic e);
        aw = w; ch = c; aa = a; wd = d; av = 1;
        @(negedge mclk);
        av = 0;
        `CHK("done", done, 1'b1)
        `CHK("error", err, e)
        @(negedge mclk);
    endtask
    task automatic ev(input logic rt, input logic [15:0] c, input logic [2:0] k);
        rtb = rt; mev = !rt; mcode = c; mcl = k;
        @(negedge mclk);
        rtb = 0; mev = 0;
        `CHK("msg", mv, 1'b1)
        `CHK("code", code, c)
        `CHK("class", cls, {13'h0, k})
        `CHK("range", rng, c[15:12])
        repeat (2) @(negedge mclk);
    endtask
    task automatic pulse_reset;
        frs = 1; @(negedge mclk); frs = 0; repeat (2) @(negedge mclk);
    endtask
    initial begin
        #50us; n_mismatch++; print_verdict;
    end
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 0; @(negedge mclk);
        acc(0, 0, 16'h190c, 0, 0); `CHK("deflt", rd, 16'h0000)
        for (i = 0; i < 7; i++) begin
            acc(1, 0, ra[i], rw[i], 1);
            `CHK("refuse", code, rc[i])
        end
        acc(0, 0, 16'h190c, 0, 0); `CHK("kept", rd, 16'h0000)
        acc(0, 1, 16'h190c, 0, 1); `CHK("chan", code, 16'h1107)
        $display("refusal test done");
        ev(1, 16'h1100, 3'h0); `CHK("rt0", fs, 1'b0)
        rel = 1; ch = 0; @(negedge mclk); rel = 0;
        acc(1, 1, 16'h190c, 16'h1, 0);
        acc(0, 1, 16'h190c, 0, 0); `CHK("set", rd, 16'h0001)
        ev(1, 16'h1100, 3'h1); `CHK("rt1", fs, 1'b1)
        pulse_reset; `CHK("rtclr", fs, 1'b0)
        $display("realtime class test done");
        for (i = 0; i < 10; i++) ev(0, {rg[i], 12'h0ab}, 3'h0);
        pulse_reset;
        for (i = 0; i < 5; i++) begin
            ev(0, 16'h2300 + i, i[2:0]);
            `CHK("fstop", fs, i == 1 || i == 2)
            `CHK("t11", t11, i == 1)
            `CHK("t13", t13, i > 1)
            `CHK("sdis", sd, i > 2)
            `CHK("sen", se, i < 3)
            `CHK("fact", fa, 1'b1)
            `CHK("rec", rec, 16'(i))
            if (i == 2) begin
                still = 1; repeat (3) @(negedge mclk);
                `CHK("stand", sd, 1'b1)
                `CHK("t14", t14, 1'b1)
                still = 0;
            end
            pulse_reset;
            `CHK("clr", rec, (i == 4) ? 16'h0004 : 16'h0000)
            `CHK("fclr", fa, i == 4)
        end
        por = 1; @(negedge mclk); por = 0; @(negedge mclk);
        `CHK("pcyc", rec, 16'h0000)
        $display("class response test done");
        print_verdict;
    end
endmodule
